/* File: common/fpi_pkg.sv */
// constants shared by the flow pulse interpolator and its register block
// assumes a 200 MHz pclk and APB with 32-bit data
package fpi_pkg;
  localparam int unsigned CLK_MHZ = 200;
  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_ACTIVE = 8'h08;
  localparam logic [7:0] REG_POS = 8'h0C;
  // ctrl fields
  localparam int CTRL_OFFSET_REQ = 0;
  localparam int CTRL_CFG_FAULT = 1;
  localparam int CTRL_OVERLOAD = 2;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  // status fields
  localparam int ST_DIR = 0;
  localparam int ST_SUPP = 1;
  localparam int ST_PICKUP = 2;
  localparam int ST_FREQ = 3;
  localparam int ST_GREEN = 4;
  localparam int ST_YELLOW = 5;
  localparam int ST_RED = 6;
  localparam int ST_FAULT = 7;
  // timing
  localparam int unsigned DEBOUNCE_US = 10;
  localparam int unsigned DEBOUNCE_CYC = DEBOUNCE_US * CLK_MHZ;
  localparam int unsigned FLASH_MS = 250;
  localparam int unsigned FLASH_CYC = FLASH_MS * 1000 * CLK_MHZ;
  localparam int unsigned PICKUP_MS = 500;
  localparam int unsigned PICKUP_CYC = PICKUP_MS * 1000 * CLK_MHZ;
  // fastest legal output: 100 kHz means quadrature step every 2.5 us
  localparam int unsigned FMAX_HZ = 100000;
  localparam int unsigned MIN_STEP_CYC = CLK_MHZ * 1000000 / (FMAX_HZ * 4);
  localparam int unsigned FACTOR_CNT = 10;
  localparam int unsigned QUARTERS_PER_GEAR = 4;
  typedef enum logic [1:0] {FPI_IDLE, FPI_RUN} fpi_state_t;
endpackage

/* File: src/fpi_factor_rom.sv */
// factor lookup: selector position to output pulses per gear unit
// assumes a registered read, one cycle of latency
`timescale 1ns/1ps
module fpi_factor_rom
  import fpi_pkg::*;
(
  // clock
  input wire logic pclk,
  input wire logic presetn,
  // lookup
  input wire logic [3:0] sel,
  output logic [7:0] factor
);
  function automatic logic [7:0] fpi_lut(input logic [3:0] s);
    case (s)
      4'h0: fpi_lut = 8'h01;
      4'h1: fpi_lut = 8'h02;
      4'h2: fpi_lut = 8'h05;
      4'h3: fpi_lut = 8'h0A;
      4'h4: fpi_lut = 8'h19;
      4'h5: fpi_lut = 8'h20;
      4'h6: fpi_lut = 8'h32;
      4'h7: fpi_lut = 8'h40;
      4'h8: fpi_lut = 8'h64;
      4'h9: fpi_lut = 8'h80;
      default: fpi_lut = 8'h01; // unused positions fall back to 1
    endcase
  endfunction

  // registered read keeps the factor glitch-free
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      factor <= 8'h01;
    end else begin
      factor <= fpi_lut(sel);
    end
  end
endmodule

/* File: src/fpi_core.sv */
// flow pulse interpolator with filter, quadrature outputs, leds, apb
// assumes sensor edges as one-cycle pulses synchronous to pclk
// assumes the key is a raw contact and every other pin is synchronous
// Summary of operation
// - direction switch read at reset selects preferred direction
// - jumper selects direction or fault output
// - ten interpolation factors from 1 to 128
// - factor loads only on acknowledge press; here it also loads once in the first cycle after reset
// - sixteen filter settings in quarter gears
// - filter setting loads on acknowledge press
// - net reverse motion, suppress until cleared; here backflow beyond the filter window is passed
// - normal green steady, offset mode flashes
// - five events, serious ones drive fault
// - red indicator mirrors fault output
// - offset warning: yellow flashes, green on
// - config fault: yellow red flash, pulse
// - pickup failure: red steady, fault high
// - overload: yellow red on, fault high
// - rate overrun: red flashes, fault pulses
// - two channels in quadrature
// - direction high positive, fault high/pulse
//
// Implementation choices: the address map and the APB register port.
`timescale 1ns/1ps
module fpi_core
  import fpi_pkg::*;
#(
  parameter int unsigned DEB_CYC = DEBOUNCE_CYC,
  parameter int unsigned FLASH_PERIOD = FLASH_CYC,
  parameter int unsigned PICKUP_TIMEOUT = PICKUP_CYC,
  parameter int unsigned MIN_STEP = MIN_STEP_CYC,
  parameter int unsigned SUB_STEPS = 128
)
(
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // switches and key
  input wire logic direction_pref_switch,
  input wire logic acknowledge_key,
  input wire logic [3:0] interp_factor_selector,
  input wire logic [3:0] filter_selector,
  input wire logic third_output_jumper,
  // sensor: one pulse per gear edge, with its direction
  input wire logic gear_edge,
  input wire logic gear_fwd,
  // outputs
  output logic chan_a,
  output logic chan_b,
  output logic flow_direction_out,
  output logic led_green,
  output logic led_yellow,
  output logic led_red
);
  // one gear edge is four quarters of filter window
  localparam logic signed [15:0] GEAR_QTR = 16'(QUARTERS_PER_GEAR);
  localparam logic signed [15:0] OFFSET_MAX = 16'sh7FFF;
  // software control
  logic [31:0] ctrl;
  // key path
  logic ack_s0, ack_s1, ack_stable, ack_pulse;
  logic [31:0] deb_cnt;
  // active settings
  logic [3:0] fsel_act, isel_act;
  logic [7:0] interp_factor;
  logic pref_pos;
  logic strap_taken;
  // filter, queue and indication state
  logic signed [15:0] offset_q;
  logic suppress;
  logic [15:0] pending;
  logic [1:0] quad_phase;
  logic [31:0] step_cnt;
  logic freq_err;
  logic [31:0] flash_cnt;
  logic flash;
  logic [31:0] pick_cnt;
  logic pickup_err;
  logic fault_pulse, fault_out;
  fpi_state_t state;
  logic dir_now;
  logic [15:0] limit;

  // strap captured by a clock edge after release, never by the reset itself
  // a switch moved while running takes effect only at the next reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_taken <= 1'b0;
      pref_pos <= 1'b1;
    end else if (!strap_taken) begin
      strap_taken <= 1'b1;
      pref_pos <= direction_pref_switch;
    end
  end

  // two-stage synchroniser on the key
  // the key is a raw contact; only ack_s1 is read past this point
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_s0 <= 1'b0;
      ack_s1 <= 1'b0;
    end else begin
      ack_s0 <= acknowledge_key;
      ack_s1 <= ack_s0;
    end
  end

  // debounce: level must hold DEB_CYC cycles; rising of the clean level
  // gives one pulse, so contact bounce never loads twice
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      deb_cnt <= 32'h0000_0000;
      ack_stable <= 1'b0;
      ack_pulse <= 1'b0;
    end else begin
      ack_pulse <= 1'b0;
      if (ack_s1 == ack_stable) begin
        deb_cnt <= 32'h0000_0000;
      end else if (deb_cnt >= DEB_CYC - 1) begin
        deb_cnt <= 32'h0000_0000;
        ack_stable <= ack_s1;
        ack_pulse <= ack_s1;
      end else begin
        deb_cnt <= deb_cnt + 32'h0000_0001;
      end
    end
  end

  // selectors are only loaded on a clean press, not while turning
  // the first cycle after reset takes the switches so the block starts set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      isel_act <= 4'h0;
      fsel_act <= 4'h0;
      state <= FPI_IDLE;
    end else begin
      case (state)
        FPI_IDLE: begin
          isel_act <= interp_factor_selector;
          fsel_act <= filter_selector;
          state <= FPI_RUN;
        end
        FPI_RUN: begin
          // turning a selector alone changes nothing until a press
          if (ack_pulse) begin
            isel_act <= interp_factor_selector;
            fsel_act <= filter_selector;
          end
        end
        default: state <= FPI_IDLE;
      endcase
    end
  end

  // factor follows one cycle after the selector position loads
  fpi_factor_rom u_rom (
    .pclk(pclk),
    .presetn(presetn),
    .sel(isel_act),
    .factor(interp_factor)
  );

  // filter window in quarter gears; each gear edge counts four quarters
  // a filter of zero turns suppression off entirely
  assign limit = 16'(fsel_act);
  assign dir_now = gear_fwd ~^ pref_pos;

  // offset against the preferred direction, netted both ways
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      offset_q <= 16'sh0000;
    end else if (gear_edge) begin
      if (!dir_now) begin
        // saturate so a long reverse run can never wrap the sign
        if (offset_q <= OFFSET_MAX - GEAR_QTR) begin
          offset_q <= offset_q + GEAR_QTR;
        end
      end else if (offset_q > 16'sh0000) begin
        offset_q <= offset_q - GEAR_QTR;
      end
    end
  end

  // outputs held back while reverse offset is outstanding
  // backflow beyond the window is passed rather than held forever
  assign suppress = (offset_q > 16'sh0000) && (fsel_act != 4'h0) &&
                    (16'(offset_q) <= limit + 16'(GEAR_QTR));

  // each passing gear edge queues interp_factor quadrature steps
  // steps leave MIN_STEP cycles apart; edges faster than that grow the
  // queue, and the next edge that finds it busy raises freq_err
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pending <= 16'h0000;
      step_cnt <= 32'h0000_0000;
      quad_phase <= 2'b00;
      freq_err <= 1'b0;
    end else begin
      if (step_cnt != 32'h0000_0000) begin
        step_cnt <= step_cnt - 32'h0000_0001;
      end
      if (gear_edge && dir_now && !suppress) begin
        // a new edge with steps still queued means the rate is too high
        freq_err <= pending > 16'h0000;
        pending <= pending + {8'h00, interp_factor} -
                   ((pending != 16'h0000 && step_cnt == 32'h0000_0000) ?
                    16'h0001 : 16'h0000);
      end else if (pending != 16'h0000 && step_cnt == 32'h0000_0000) begin
        pending <= pending - 16'h0001;
      end
      if (pending != 16'h0000 && step_cnt == 32'h0000_0000) begin
        step_cnt <= MIN_STEP - 1;
        quad_phase <= pref_pos ? quad_phase + 2'b01 : quad_phase - 2'b01;
      end
    end
  end

  // gray sequence: b leads a by a quarter period when counting up
  // registered so the pins never glitch between phases
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chan_a <= 1'b0;
      chan_b <= 1'b0;
    end else begin
      chan_a <= quad_phase[1];
      chan_b <= quad_phase[1] ^ quad_phase[0];
    end
  end

  // pickup watchdog: no gear edge for a long time while steps were due
  // overload masks it so a flow peak is not taken for a dead sensor
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pick_cnt <= 32'h0000_0000;
      pickup_err <= 1'b0;
    end else if (gear_edge) begin
      pick_cnt <= 32'h0000_0000;
      pickup_err <= 1'b0;
    end else if (ctrl[CTRL_OVERLOAD] == 1'b0 && pending != 16'h0000) begin
      if (pick_cnt >= PICKUP_TIMEOUT - 1) begin
        pickup_err <= 1'b1;
      end else begin
        pick_cnt <= pick_cnt + 32'h0000_0001;
      end
    end
  end

  // flash clock shared by leds and pulsing fault
  // one counter keeps every blinking signal in step
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flash_cnt <= 32'h0000_0000;
      flash <= 1'b0;
    end else if (flash_cnt >= FLASH_PERIOD - 1) begin
      flash_cnt <= 32'h0000_0000;
      flash <= ~flash;
    end else begin
      flash_cnt <= flash_cnt + 32'h0000_0001;
    end
  end

  // event priority: config fault, pickup, overload, frequency, offset
  // one message shows at a time; the most harmful one wins
  assign fault_pulse = ctrl[CTRL_CFG_FAULT] ||
                       (freq_err && !pickup_err && !ctrl[CTRL_OVERLOAD]);
  always_comb begin
    // defaults are the normal operating picture
    fault_out = 1'b0;
    led_green = 1'b1;
    led_yellow = 1'b0;
    led_red = 1'b0;
    if (ctrl[CTRL_CFG_FAULT]) begin
      led_green = 1'b0;
      led_yellow = flash;
      fault_out = flash;
    end else if (pickup_err) begin
      fault_out = 1'b1;
    end else if (ctrl[CTRL_OVERLOAD]) begin
      led_green = 1'b0;
      led_yellow = 1'b1;
      fault_out = 1'b1;
    end else if (fault_pulse) begin
      led_yellow = 1'b1;
      fault_out = flash;
    end else if (ctrl[CTRL_OFFSET_REQ]) begin
      led_yellow = flash;
    end else if (suppress) begin
      led_green = flash;
    end
    // red is wired to the fault signal so the two never disagree
    led_red = fault_out;
  end

  // third output: direction level or fault signal
  // registered, so it trails the red led by one clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flow_direction_out <= 1'b0;
    end else if (third_output_jumper) begin
      flow_direction_out <= fault_out;
    end else begin
      flow_direction_out <= gear_fwd;
    end
  end

  // apb: zero wait states, unmapped reads zero with error
  // ctrl stands in for the conditions no sensor here can detect
  assign pready = 1'b1;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= CTRL_RESET;
    end else if (psel && penable && pwrite && paddr == REG_CTRL) begin
      ctrl <= {29'h0, pwdata[2:0]};
    end
  end
  // reads have no side effects, so any order of access is safe
  always_comb begin
    prdata = 32'h0000_0000;
    pslverr = 1'b0;
    if (paddr == REG_CTRL) begin
      prdata = ctrl;
    end else if (paddr == REG_STATUS) begin
      prdata = {24'h0, fault_out, led_red, led_yellow, led_green,
                freq_err, pickup_err, suppress, pref_pos};
    end else if (paddr == REG_ACTIVE) begin
      prdata = {16'h0, interp_factor, fsel_act, isel_act};
    end else if (paddr == REG_POS) begin
      prdata = {16'h0, pending};
    end else begin
      // flagged only in the access phase, as the bus expects
      pslverr = psel && penable;
    end
  end
endmodule

/* File: bench/fpi_core_sva.sv */
// port assertions for the flow pulse interpolator
// assumes binding onto fpi_core with MIN_STEP of two or more
`timescale 1ns/1ps
module fpi_core_sva (
  // clock and apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  // pins
  input wire logic third_output_jumper,
  input wire logic gear_fwd,
  input wire logic chan_a,
  input wire logic chan_b,
  input wire logic flow_direction_out,
  input wire logic led_red
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // access phase, then a level held three edges on the third pin
  sequence s_acc;
    psel && penable;
  endsequence
  sequence s_hold(bit v);
    (!third_output_jumper && gear_fwd == v)[*3];
  endsequence
  a_zero_wait: assert property (s_acc |-> pready)
    else $error("access phase without ready");
  a_err_unmapped: assert property (s_acc ##0
    !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0C}) |-> pslverr)
    else $error("unmapped access not refused");
  a_err_mapped: assert property (s_acc ##0
    (paddr inside {8'h00, 8'h04, 8'h08, 8'h0C}) |-> !pslverr)
    else $error("mapped access refused");
  a_quad_one_bit: assert property (!($changed(chan_a) && $changed(chan_b)))
    else $error("both channels moved at once");
  a_step_spacing: assert property ($changed({chan_a, chan_b}) |=>
    $stable({chan_a, chan_b})) else $error("steps too close");
  a_dir_pos: assert property (s_hold(1'b1) |-> flow_direction_out)
    else $error("direction low in positive flow");
  a_dir_neg: assert property (s_hold(1'b0) |-> !flow_direction_out)
    else $error("direction high in negative flow");
  a_red_mirror: assert property ((third_output_jumper && !led_red)[*3]
    |-> !flow_direction_out) else $error("fault without red");
endmodule

/* File: bench/fpi_count_model.sv */
// receiving counter that follows the two quadrature channels
// assumes channels change on pclk, one step at a time
`timescale 1ns/1ps
module fpi_count_model (
  // clock
  input wire logic pclk,
  input wire logic presetn,
  // channels
  input wire logic chan_a,
  input wire logic chan_b,
  // signed position
  output int steps
);
  logic pa;
  logic pb;
  // x4 decode: which channel leads gives the sign of each step
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pa <= 1'b0;
      pb <= 1'b0;
      steps <= 0;
    end else begin
      pa <= chan_a;
      pb <= chan_b;
      if ((pa ^ chan_a) || (pb ^ chan_b)) begin
        steps <= steps + ((pa ^ chan_b) ? 1 : -1);
      end
    end
  end
endmodule

/* File: bench/fpi_core_bench.sv */
// self-checking bench for fpi_core with a receiving counter
// assumes shortened timing parameters for a quick run
`timescale 1ns/1ps
module fpi_core_bench;
  import fpi_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, d;
  logic pready, pslverr, chan_a, chan_b, flow_direction_out;
  logic led_green, led_yellow, led_red, gear_edge = 0, gear_fwd = 1;
  logic direction_pref_switch = 1, acknowledge_key = 0;
  logic third_output_jumper = 0;
  logic [3:0] interp_factor_selector = 0, filter_selector = 0;
  logic [7:0] fac [10] = '{8'h01, 8'h02, 8'h05, 8'h0A, 8'h19, 8'h20,
    8'h32, 8'h40, 8'h64, 8'h80};
  logic [65:0] exp_q [$];
  int err_count = 0, n_compared = 0, cyc = 0, steps, s0;
  always #2.5 pclk = ~pclk;
  fpi_core #(.DEB_CYC(4), .FLASH_PERIOD(8), .PICKUP_TIMEOUT(64),
    .MIN_STEP(2)) dut_u (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .direction_pref_switch,
    .acknowledge_key, .interp_factor_selector, .filter_selector,
    .third_output_jumper, .gear_edge, .gear_fwd, .chan_a, .chan_b,
    .flow_direction_out, .led_green, .led_yellow, .led_red);
  fpi_count_model rx_u (.pclk, .presetn, .chan_a, .chan_b, .steps);
  task automatic test_done();
    if (err_count == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic cmp(logic [32:0] got, logic [32:0] ex, logic [32:0] m);
    n_compared++;
    if ((got & m) !== (ex & m)) begin
      err_count++;
      $display("wrong value at %0t: %h, expected %h", $time, got & m, ex & m);
    end
  endtask
  // one transfer; held until pready is seen at a rising edge
  task automatic apb(logic wr, logic [7:0] a, logic [31:0] wd);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 0;
    penable <= 0;
    // an idle edge so a following call never re-raises psel at once
    @(posedge pclk);
  endtask
  task automatic rd(logic [7:0] a, logic [32:0] ex, logic [32:0] m);
    exp_q.push_back({m, ex});
    apb(0, a, 32'h0);
  endtask
  // held well past the debounce so one press gives one load
  task automatic press();
    acknowledge_key <= 1;
    repeat (12) @(posedge pclk);
    acknowledge_key <= 0;
    repeat (12) @(posedge pclk);
  endtask
  task automatic edge_in(logic fwd, int n);
    gear_fwd <= fwd;
    gear_edge <= 1;
    @(posedge pclk);
    gear_edge <= 0;
    repeat (n) @(posedge pclk);
  endtask
  // read results are taken off the queue as each access completes
  always @(posedge pclk) begin
    cyc++;
    if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size()) begin
      cmp({pslverr, prdata}, exp_q[0][32:0], exp_q[0][65:33]);
      void'(exp_q.pop_front());
    end
    if (cyc == 20000) begin
      err_count++;
      test_done();
    end
  end
  initial begin
    void'($urandom(37));
    repeat (20) @(posedge pclk);
    presetn <= 1;
    repeat (3) @(posedge pclk);
    rd(REG_STATUS, 33'h1, 33'h1);
    for (int i = 0; i < 16; i++) begin
      interp_factor_selector <= 4'(i % 10);
      filter_selector <= 4'(i);
      press();
      rd(REG_ACTIVE, {17'h0, fac[i % 10], 4'(i), 4'(i % 10)}, '1);
    end
    interp_factor_selector <= 4'h1;
    filter_selector <= 4'h4;
    repeat (20) @(posedge pclk);
    rd(REG_ACTIVE, {17'h0, 8'h20, 4'hF, 4'h5}, '1);
    press();
    repeat (5) edge_in(1'b1, 20);
    cmp(33'(steps), 33'd10, '1);
    s0 = steps;
    edge_in(1'b0, 20);
    rd(REG_STATUS, 33'h2, 33'h2);
    edge_in(1'b1, 20);
    cmp(33'(steps), 33'(s0), '1);
    d = $urandom;
    apb(1, REG_CTRL, d);
    rd(REG_CTRL, {30'h0, d[2:0]}, '1);
    apb(1, 8'h10, d);
    rd(8'h10, 33'h1_0000_0000, 33'h1_0000_0000);
    third_output_jumper <= 1;
    foreach (fac[j]) if (j < 3) begin
      apb(1, REG_CTRL, 32'(1 << j));
      repeat (4) @(posedge pclk);
      cmp({flow_direction_out, led_red, led_yellow, led_green},
        j == 0 ? 4'h1 : j == 1 ? 4'h0 : 4'hE,
        j == 0 ? 4'hD : j == 1 ? 4'h1 : 4'hF);
    end
    apb(1, REG_CTRL, 32'h0);
    interp_factor_selector <= 4'h9;
    press();
    edge_in(1'b1, 80);
    rd(REG_STATUS, 33'h4, 33'h4);
    cmp({flow_direction_out, led_red, led_yellow}, 3'h6, 3'h7);
    edge_in(1'b1, 2);
    rd(REG_STATUS, 33'h8, 33'h8);
    // second reset with negative preferred flow and factor 1
    direction_pref_switch <= 0;
    interp_factor_selector <= 4'h0;
    presetn <= 0;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    repeat (3) @(posedge pclk);
    rd(REG_STATUS, 33'h0, 33'h1);
    cmp({flow_direction_out, led_red, led_yellow, led_green}, 4'h1,
      4'hF);
    edge_in(1'b0, 20);
    cmp(33'(steps), 33'(-1), '1);
    repeat (3) @(posedge pclk);
    test_done();
  end
endmodule
bind fpi_core fpi_core_sva chk_u (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .paddr(paddr), .pready(pready),
  .pslverr(pslverr), .third_output_jumper(third_output_jumper),
  .gear_fwd(gear_fwd), .chan_a(chan_a), .chan_b(chan_b),
  .flow_direction_out(flow_direction_out), .led_red(led_red));
